/* design/shift_move_indirect_pkg.sv */
package shift_move_indirect_pkg;

	// Operand and datapath widths, and the number of pointers.
	localparam int DATA_W = 8;
	localparam int FILE_ADDR_W = 7;
	localparam int PTR_W = 16;
	localparam int OFFSET_W = 6;
	localparam int MODE_W = 2;
	localparam int PTR_COUNT = 2;

	// Bit positions of the shifted byte.
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;

	// Pointer update modes as carried in the instruction word.
	localparam logic [MODE_W-1:0] MODE_PRE_INC = 2'h0;
	localparam logic [MODE_W-1:0] MODE_PRE_DEC = 2'h1;
	localparam logic [MODE_W-1:0] MODE_POST_INC = 2'h2;
	localparam logic [MODE_W-1:0] MODE_POST_DEC = 2'h3;

	// File addresses of the two indirect windows.
	localparam logic [FILE_ADDR_W-1:0] WINDOW0_ADDR = 7'h00;
	localparam logic [FILE_ADDR_W-1:0] WINDOW1_ADDR = 7'h01;

	// Destination select encoding.
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// Reset values and datapath constants.
	localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;

	// Instructions this datapath executes.
	typedef enum logic [1:0] {
		OP_IDLE,
		OP_SHIFT_RIGHT,
		OP_COPY,
		OP_INDIRECT_LOAD
	} exec_op_t;

	// True when a file address names one of the indirect windows.
	function automatic logic is_window(input logic [FILE_ADDR_W-1:0] addr);
		is_window = (addr == WINDOW0_ADDR) || (addr == WINDOW1_ADDR);
	endfunction

	// Index of the pointer behind a window address.
	function automatic logic window_ptr(input logic [FILE_ADDR_W-1:0] addr);
		window_ptr = (addr == WINDOW1_ADDR);
	endfunction

endpackage

/* design/pointer_step_if.sv */
interface pointer_step_if;
	import shift_move_indirect_pkg::*;

	logic [PTR_W-1:0] ptr;
	logic [MODE_W-1:0] mode;
	logic relative;
	logic signed [OFFSET_W-1:0] offset;
	logic [PTR_W-1:0] eff_addr;
	logic [PTR_W-1:0] ptr_next;

	modport calc(
		input ptr,
		input mode,
		input relative,
		input offset,
		output eff_addr,
		output ptr_next
	);

	modport user(
		output ptr,
		output mode,
		output relative,
		output offset,
		input eff_addr,
		input ptr_next
	);

endinterface

/* design/pointer_step.sv */
module pointer_step
	import shift_move_indirect_pkg::*;
(
	pointer_step_if.calc step
);

	logic [PTR_W-1:0] offset_ext;
	logic [PTR_W-1:0] ptr_inc;
	logic [PTR_W-1:0] ptr_dec;

	// Sixteen-bit sums wrap by themselves, so no range check is needed at either end.
	always_comb begin
		offset_ext = {{(PTR_W-OFFSET_W){step.offset[OFFSET_W-1]}}, step.offset};
		ptr_inc = step.ptr + PTR_ONE;
		ptr_dec = step.ptr - PTR_ONE;
	end

	// Effective address and the pointer value left behind.
	always_comb begin
		step.eff_addr = step.ptr;
		step.ptr_next = step.ptr;
		if (step.relative) begin
			step.eff_addr = step.ptr + offset_ext;
			step.ptr_next = step.ptr;
		end else begin
			case (step.mode)
				MODE_PRE_INC: begin
					step.eff_addr = ptr_inc;
					step.ptr_next = ptr_inc;
				end
				MODE_PRE_DEC: begin
					step.eff_addr = ptr_dec;
					step.ptr_next = ptr_dec;
				end
				MODE_POST_INC: begin
					step.eff_addr = step.ptr;
					step.ptr_next = ptr_inc;
				end
				MODE_POST_DEC: begin
					step.eff_addr = step.ptr;
					step.ptr_next = ptr_dec;
				end
				default: begin
					step.eff_addr = step.ptr;
					step.ptr_next = step.ptr;
				end
			endcase
		end
	end

endmodule // pointer_step

/* design/shift_move_indirect_exec.sv */
// Overview of operation
// - A right shift moves source bits 7..1 into result bits 6..0 and source bit 0 into carry.
// - The right shift always fills the top result bit with zero.
// - The shift result goes to the accumulator when the destination bit is 0, else back to the file register.
// - A copy delivers the file register to the accumulator, or rewrites it unchanged when the destination bit is 1.
// - A copy updates the zero flag from the copied value whichever destination is chosen.
// - The indirect load address is pointer+1, pointer-1 or pointer+offset in pre and relative modes, else the pointer.
// - After the indirect load the pointer is +1 for increments, -1 for decrements and unchanged for relative.
// - The indirect load picks one of two pointers by a one-bit index, a two-bit mode and a signed offset -32..31.
// - The indirect windows hold no data; accessing window 0 or 1 reaches the byte that pointer 0 or 1 addresses.
// - Pointers are 16 bits and wrap modulo 2^16 past either end.
module shift_move_indirect_exec
	import shift_move_indirect_pkg::*;
#(
	parameter int MEM_DEPTH = 256
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic op_valid,
	input wire exec_op_t op_code,
	input wire logic [FILE_ADDR_W-1:0] file_addr,
	input wire logic dest_sel,
	input wire logic ptr_sel,
	input wire logic [MODE_W-1:0] ptr_mode,
	input wire logic relative,
	input wire logic signed [OFFSET_W-1:0] rel_offset,
	input wire logic ptr_load_en,
	input wire logic ptr_load_sel,
	input wire logic [PTR_W-1:0] ptr_load_value,
	input wire logic mem_wr_en,
	input wire logic [PTR_W-1:0] mem_wr_addr,
	input wire logic [DATA_W-1:0] mem_wr_data,
	input wire logic [PTR_W-1:0] peek_addr,
	output logic [DATA_W-1:0] acc,
	output logic carry,
	output logic zero,
	output logic [PTR_W-1:0] ptr0,
	output logic [PTR_W-1:0] ptr1,
	output logic done,
	output logic [DATA_W-1:0] peek_data
);

	localparam int MEM_AW = $clog2(MEM_DEPTH);

	// The memory must be a power of two and must hold all file addresses. The check
	// runs at elaboration, so a bad depth is refused before any logic is built and
	// never shows up later as silent address aliasing.
	if (MEM_DEPTH < (1 << FILE_ADDR_W) || MEM_DEPTH > (1 << PTR_W) || (1 << MEM_AW) != MEM_DEPTH) begin : g_bad_depth
		$error("MEM_DEPTH must be a power of two between 128 and 65536");
	end

	// Data memory and pointer registers; the memory has no reset, so the loader fills it.
	logic [DATA_W-1:0] data_mem [MEM_DEPTH];
	logic [PTR_W-1:0] ptr_reg [PTR_COUNT];
	logic [DATA_W-1:0] acc_reg;
	logic [DATA_W-1:0] acc_next;
	logic carry_reg;
	logic carry_next;
	logic zero_reg;
	logic zero_next;
	logic done_reg;
	logic [DATA_W-1:0] peek_reg;

	// Decoded controls and datapath values of the current instruction.
	logic exec_shift;
	logic exec_copy;
	logic exec_load;
	logic file_op;
	logic [PTR_W-1:0] src_addr;
	logic [DATA_W-1:0] src_byte;
	logic [DATA_W-1:0] result;
	logic wb_en;
	logic update_carry;
	logic mem_we;
	logic [MEM_AW-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;

	pointer_step_if step_bus();

	pointer_step u_pointer_step (
		.step(step_bus)
	);

	// Operation decode from the instruction fields.
	always_comb begin
		exec_shift = op_valid && (op_code == OP_SHIFT_RIGHT);
		exec_copy = op_valid && (op_code == OP_COPY);
		exec_load = op_valid && (op_code == OP_INDIRECT_LOAD);
		file_op = exec_shift || exec_copy;
	end

	// The address unit sees the pointer chosen by the one-bit index.
	always_comb begin
		step_bus.ptr = ptr_reg[ptr_sel];
		step_bus.mode = ptr_mode;
		step_bus.relative = relative;
		step_bus.offset = rel_offset;
	end

	// Source address: a window has no storage, so its pointer's target is used instead.
	always_comb begin
		src_addr = {{(PTR_W-FILE_ADDR_W){1'b0}}, file_addr};
		if (exec_load) begin
			src_addr = step_bus.eff_addr;
		end else if (is_window(file_addr)) begin
			src_addr = ptr_reg[window_ptr(file_addr)];
		end
		src_byte = data_mem[src_addr[MEM_AW-1:0]];
	end

	// Result and flag values. Only the low address bits reach the memory, so a
	// pointer beyond MEM_DEPTH aliases onto it rather than faulting.
	always_comb begin
		result = src_byte;
		update_carry = 1'b0;
		carry_next = carry_reg;
		if (exec_shift) begin
			result = {1'b0, src_byte[DATA_MSB:DATA_LSB+1]};
			carry_next = src_byte[DATA_LSB];
			update_carry = 1'b1;
		end
		zero_next = (result == DATA_ZERO);
		wb_en = file_op && (dest_sel == DEST_FILE);
		acc_next = acc_reg;
		if (exec_load || (file_op && dest_sel == DEST_ACC)) begin
			acc_next = result;
		end
	end

	// Accumulator update.
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg <= ACC_RESET;
		end else begin
			acc_reg <= acc_next;
		end
	end

	// Carry only moves on a shift; every other instruction leaves it alone.
	always_ff @(posedge clk) begin
		if (rst) begin
			carry_reg <= 1'b0;
		end else if (update_carry) begin
			carry_reg <= carry_next;
		end
	end

	// Zero moves on every executed instruction, so a copy back to its own register works as a test.
	always_ff @(posedge clk) begin
		if (rst) begin
			zero_reg <= 1'b0;
		end else if (exec_shift || exec_copy || exec_load) begin
			zero_reg <= zero_next;
		end
	end

	// One register per pointer. The instruction's own update wins over a load of the
	// same pointer; the load is dropped rather than merged with the step.
	for (genvar g = 0; g < PTR_COUNT; g++) begin : g_ptr
		always_ff @(posedge clk) begin
			if (rst) begin
				ptr_reg[g] <= PTR_RESET;
			end else if (exec_load && !relative && (int'(ptr_sel) == g)) begin
				ptr_reg[g] <= step_bus.ptr_next;
			end else if (ptr_load_en && (int'(ptr_load_sel) == g)) begin
				ptr_reg[g] <= ptr_load_value;
			end
		end
	end

	// Write port select. Write-back from an instruction has priority; a loader
	// write in the same cycle is dropped so the two never collide on the one port.
	// A loader that writes during an instruction must therefore retry afterwards.
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = mem_wr_addr[MEM_AW-1:0];
		mem_wdata = mem_wr_data;
		if (wb_en) begin
			mem_we = 1'b1;
			mem_waddr = src_addr[MEM_AW-1:0];
			mem_wdata = result;
		end else if (mem_wr_en && !op_valid) begin
			mem_we = 1'b1;
		end
	end

	// Data memory write.
	always_ff @(posedge clk) begin
		if (mem_we) begin
			data_mem[mem_waddr] <= mem_wdata;
		end
	end

	// Completion pulse, high for the one cycle after an executed instruction.
	always_ff @(posedge clk) begin
		if (rst) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= exec_shift || exec_copy || exec_load;
		end
	end

	// Registered observation port; it shows the byte as it stood before this edge's write.
	always_ff @(posedge clk) begin
		if (rst) begin
			peek_reg <= DATA_ZERO;
		end else begin
			peek_reg <= data_mem[peek_addr[MEM_AW-1:0]];
		end
	end

	// Every output is a flip-flop.
	assign acc = acc_reg;
	assign carry = carry_reg;
	assign zero = zero_reg;
	assign ptr0 = ptr_reg[0];
	assign ptr1 = ptr_reg[1];
	assign done = done_reg;
	assign peek_data = peek_reg;

endmodule // shift_move_indirect_exec

/* verification/shift_move_indirect_assertions.sv */
module shift_move_indirect_checker
	import shift_move_indirect_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic op_valid,
	input wire exec_op_t op_code,
	input wire logic dest_sel,
	input wire logic ptr_sel,
	input wire logic [MODE_W-1:0] ptr_mode,
	input wire logic relative,
	input wire logic ptr_load_en,
	input wire logic [DATA_W-1:0] acc,
	input wire logic carry,
	input wire logic zero,
	input wire logic [PTR_W-1:0] ptr0,
	input wire logic [PTR_W-1:0] ptr1,
	input wire logic done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Instruction qualifiers; a stepping load never honours a same-cycle load of its pointer.
	wire exe = op_valid && op_code != OP_IDLE;
	wire shf = op_valid && op_code == OP_SHIFT_RIGHT;
	wire ld = op_valid && op_code == OP_INDIRECT_LOAD;

	chk_done_pulse: assert property (exe |=> done) else $error("done missing");
	chk_done_idle: assert property (!exe |=> !done) else $error("spurious done");
	chk_carry_hold: assert property (!shf |=> $stable(carry)) else $error("carry moved");
	chk_shift_msb: assert property (shf && dest_sel == DEST_ACC |=> !acc[7] && zero == (acc == 8'h00))
		else $error("shift top bit or zero wrong");
	chk_acc_kept: assert property (op_valid && (shf || op_code == OP_COPY) && dest_sel == DEST_FILE |=> $stable(acc))
		else $error("acc changed on file write");
	chk_zero_flag: assert property (op_valid && (ld || op_code == OP_COPY && dest_sel == DEST_ACC) |=> zero == (acc == 8'h00))
		else $error("zero flag wrong");
	chk_ptr0_step: assert property (ld && !relative && !ptr_sel |=> ptr0 == $past(ptr0) + (ptr_mode[0] ? 16'hffff : 16'h0001))
		else $error("ptr0 step wrong");
	chk_ptr1_step: assert property (ld && !relative && ptr_sel |=> ptr1 == $past(ptr1) + (ptr_mode[0] ? 16'hffff : 16'h0001))
		else $error("ptr1 step wrong");
	chk_rel_hold: assert property (ld && relative && !ptr_load_en |=> $stable(ptr0) && $stable(ptr1))
		else $error("pointer moved in relative mode");
endmodule // shift_move_indirect_checker

bind shift_move_indirect_exec shift_move_indirect_checker chk_i(.*);

/* verification/shift_move_indirect_exec_bench.sv */
module shift_move_indirect_exec_bench
	import shift_move_indirect_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, op_valid, dest_sel, ptr_sel, relative, ptr_load_en, ptr_load_sel, mem_wr_en, carry, zero, done;
	exec_op_t op_code;
	logic [FILE_ADDR_W-1:0] file_addr;
	logic [MODE_W-1:0] ptr_mode;
	logic signed [OFFSET_W-1:0] rel_offset;
	logic [PTR_W-1:0] ptr_load_value, mem_wr_addr, peek_addr, ptr0, ptr1;
	logic [DATA_W-1:0] mem_wr_data, acc, peek_data;
	int n_mismatch, check_count;

	shift_move_indirect_exec #(.MEM_DEPTH(256)) dut(.*);

	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Loader writes are kept apart from instructions, since the design drops them then.
	// Every driving task lets one idle edge pass, so no strobe falls and rises in one step.
	task wr(input logic [15:0] a, input logic [7:0] d);
		mem_wr_en = 1;
		mem_wr_addr = a;
		mem_wr_data = d;
		@(negedge clk);
		mem_wr_en = 0;
		@(negedge clk);
	endtask

	task ldp(input logic s, input logic [15:0] v);
		ptr_load_en = 1;
		ptr_load_sel = s;
		ptr_load_value = v;
		@(negedge clk);
		ptr_load_en = 0;
		@(negedge clk);
	endtask

	task op(input exec_op_t c, input logic [6:0] fa, input logic d);
		op_valid = 1;
		op_code = c;
		file_addr = fa;
		dest_sel = d;
		@(negedge clk);
		op_valid = 0;
		chk("done", 1, done);
		@(negedge clk);
		chk("done", 0, done);
	endtask

	task pk(input logic [15:0] a, input logic [7:0] e);
		peek_addr = a;
		@(negedge clk);
		chk("peek", e, peek_data);
	endtask

	task t_shift;
		wr(16'h0010, 8'h81);
		op(OP_SHIFT_RIGHT, 7'h10, DEST_ACC);
		chk("acc", 16'h40, acc);
		chk("carry", 1, carry);
		chk("zero", 0, zero);
		wr(16'h0011, 8'h01);
		op(OP_SHIFT_RIGHT, 7'h11, DEST_FILE);
		chk("acc", 16'h40, acc);
		chk("zero", 1, zero);
		pk(16'h0011, 8'h00);
	endtask

	// Zero is made to flip on every copy, so a copy that leaves it alone is caught.
	task t_copy;
		wr(16'h0013, 8'ha5);
		op(OP_COPY, 7'h13, DEST_ACC);
		chk("acc", 16'ha5, acc);
		chk("zero", 0, zero);
		wr(16'h0012, 8'h00);
		op(OP_COPY, 7'h12, DEST_FILE);
		chk("zero", 1, zero);
		chk("acc", 16'ha5, acc);
		pk(16'h0012, 8'h00);
		op(OP_COPY, 7'h13, DEST_FILE);
		chk("zero", 0, zero);
		pk(16'h0013, 8'ha5);
	endtask

	// Each update mode from the same start pointer; data at 0x11 is zero.
	task t_load;
		logic [15:0] ea[4];
		logic [15:0] pn[4];
		ea = '{16'h00, 16'h11, 16'h22, 16'h22};
		pn = '{16'h11, 16'h0f, 16'h11, 16'h0f};
		wr(16'h000f, 8'h11);
		wr(16'h0010, 8'h22);
		wr(16'h0011, 8'h00);
		for (int m = 0; m < 4; m++) begin
			ldp(0, 16'h0010);
			ptr_sel = 0;
			ptr_mode = m[1:0];
			relative = 0;
			op(OP_INDIRECT_LOAD, 7'h00, 0);
			chk("acc", ea[m], acc);
			chk("zero", ea[m] == 0, zero);
			chk("ptr0", pn[m], ptr0);
		end
		wr(16'h0000, 8'h7c);
		wr(16'h003f, 8'h3e);
		ldp(1, 16'h0020);
		ptr_sel = 1;
		relative = 1;
		rel_offset = 6'sh20; // Most negative offset, -32.
		op(OP_INDIRECT_LOAD, 7'h00, 0);
		chk("acc", 16'h7c, acc);
		rel_offset = 6'sh1f;
		op(OP_INDIRECT_LOAD, 7'h00, 0);
		chk("acc", 16'h3e, acc);
		chk("ptr1", 16'h0020, ptr1);
	endtask

	task t_wrap;
		wr(16'h00ff, 8'h5a);
		ldp(1, 16'hffff);
		relative = 0;
		ptr_mode = MODE_POST_INC;
		op(OP_INDIRECT_LOAD, 7'h00, 0);
		chk("ptr1", 16'h0000, ptr1);
		chk("acc", 16'h5a, acc);
		ptr_mode = MODE_PRE_DEC;
		op(OP_INDIRECT_LOAD, 7'h00, 0);
		chk("ptr1", 16'hffff, ptr1);
		chk("acc", 16'h5a, acc);
	endtask

	// The window byte itself is never stored; the shift lands at the pointed byte.
	task t_window;
		ldp(1, 16'h0030);
		wr(16'h0030, 8'h06);
		op(OP_SHIFT_RIGHT, WINDOW1_ADDR, DEST_FILE);
		pk(16'h0030, 8'h03);
		chk("ptr1", 16'h0030, ptr1);
		chk("carry", 0, carry);
		op_valid = 1;
		op_code = OP_IDLE;
		@(negedge clk);
		op_valid = 0;
		chk("done", 0, done);
	endtask

	task close_out;
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: all inputs idle at time zero, reset for five cycles.
	initial begin
		{clk, op_valid, dest_sel, ptr_sel, relative, ptr_load_en, ptr_load_sel, mem_wr_en} = '0;
		rst = 1;
		op_code = OP_IDLE;
		{file_addr, ptr_mode, rel_offset, ptr_load_value, mem_wr_addr, peek_addr, mem_wr_data} = '0;
		repeat (5) @(negedge clk);
		rst = 0;
		t_shift;
		t_copy;
		t_load;
		t_wrap;
		t_window;
		close_out;
	end

	// Watchdog well beyond the 74 cycles the tests need.
	initial begin
		#20000;
		n_mismatch++;
		close_out;
	end
endmodule // shift_move_indirect_exec_bench
